// [irq_prio_pkg.sv]
// package: register map, field layout and reset values of the priority group
package irq_prio_pkg;

  // =====================================================================
  // register map
  // =====================================================================
  localparam int          NUM_REGS   = 6;
  localparam int          ADDR_W     = 5;
  localparam logic [4:0]  OFS_GRP5   = 5'h00;
  localparam logic [4:0]  OFS_GRP6   = 5'h04;
  localparam logic [4:0]  OFS_GRP7   = 5'h08;
  localparam logic [4:0]  OFS_GRP8   = 5'h0C;
  localparam logic [4:0]  OFS_GRP9   = 5'h10;
  localparam logic [4:0]  OFS_GRP10  = 5'h14;

  // =====================================================================
  // field layout
  // =====================================================================
  localparam int          FIELD_W    = 3;
  localparam int          FIELDS     = 4;
  localparam int          FLD3_LSB   = 12;
  localparam int          FLD2_LSB   = 8;
  localparam int          FLD1_LSB   = 4;
  localparam int          FLD0_LSB   = 0;
  localparam logic [15:0] IMPL_MASK  = 16'h7777;
  localparam logic [2:0]  PRIO_RESET = 3'h4;
  localparam logic [2:0]  PRIO_OFF   = 3'h0;
  localparam logic [15:0] REG_RESET  = 16'h4444;

endpackage

// [prio_field.sv]
// one 3-bit priority field with its enable decode
`timescale 1ns/1ps
module prio_field
  import irq_prio_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               rstN,
  input  wire logic               wrEn,
  input  wire logic [FIELD_W-1:0] wrData,
  output logic      [FIELD_W-1:0] level,
  output logic                    srcEnable
);

  typedef struct packed {
    logic [FIELD_W-1:0] level;
  } field_s;

  field_s state_q;
  field_s state_d;

  always_comb begin
    state_d = state_q;
    if (wrEn) begin
      state_d.level = wrData;
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      state_q <= '{level: PRIO_RESET}; // see RL5
    end else begin
      state_q <= state_d;
    end
  end

  // code is the level itself: 7 highest, 1 lowest, 0 off
  assign level     = state_q.level;                 // see RL1 see RL2
  assign srcEnable = (state_q.level != PRIO_OFF);   // see RL3

  a_zero_disables: assert property (@(posedge clk) disable iff (!rstN) // see RL3
    wrEn |=> srcEnable == ($past(wrData) != 3'h0)) else $error("enable does not follow level");
  a_write_loads: assert property (@(posedge clk) disable iff (!rstN) // see RL12
    wrEn |=> level == $past(wrData)) else $error("field write lost");

endmodule

// [irq_priority_regs.sv]
// top: six interrupt priority registers behind a classic wishbone slave
`timescale 1ns/1ps
// =====================================================================
// Overview of operation
// RL1 - A field is three bits and code 111 gives its source the top level, 7.
// RL2 - Code 001 is the lowest enabled level 1, codes in between map straight to levels 2 to 6.
// RL3 - Code 000 turns the source off so it never raises a request.
// RL4 - Bits 15, 11, 7 and 3 of each register are not built and read as zero.
// RL5 - At reset each field loads 100, priority 4.
// RL6 - Group 5 holds capture 8, capture 7, converter 2 done and external irq 1, top to bottom.
// RL7 - Group 6 holds timer 4, compare 4, compare 3 and dma channel 2 done.
// RL8 - Group 7 holds serial 2 transmit, serial 2 receive, external irq 2 and timer 5.
// RL9 - Group 8 holds can 1 event, can 1 receive ready, spi 2 event and spi 2 error.
// RL10 - Group 9 holds capture 5, capture 4, capture 3 and dma channel 3 done.
// RL11 - Group 10 holds compare 7, compare 6, compare 5 and capture 6.
// RL12 - Writes to unbuilt bits are dropped and every field is driven out continuously.
// =====================================================================
module irq_priority_regs
  import irq_prio_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [4:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             wb_err_o,
  output logic [2:0]       capture8_priority,
  output logic [2:0]       capture7_priority,
  output logic [2:0]       converter2_done_priority,
  output logic [2:0]       ext_irq1_priority,
  output logic [2:0]       timer4_priority,
  output logic [2:0]       compare4_priority,
  output logic [2:0]       compare3_priority,
  output logic [2:0]       dma_ch2_done_priority,
  output logic [2:0]       serial2_tx_priority,
  output logic [2:0]       serial2_rx_priority,
  output logic [2:0]       ext_irq2_priority,
  output logic [2:0]       timer5_priority,
  output logic [2:0]       can1_event_priority,
  output logic [2:0]       can1_rx_ready_priority,
  output logic [2:0]       spi2_event_priority,
  output logic [2:0]       spi2_error_priority,
  output logic [2:0]       capture5_priority,
  output logic [2:0]       capture4_priority,
  output logic [2:0]       capture3_priority,
  output logic [2:0]       dma_ch3_done_priority,
  output logic [2:0]       compare7_priority,
  output logic [2:0]       compare6_priority,
  output logic [2:0]       compare5_priority,
  output logic [2:0]       capture6_priority,
  output logic [23:0]      sourceEnable
);

  // =====================================================================
  // reset release
  // =====================================================================
  logic rstMeta_q;
  logic rstSync_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_q <= 1'b0;
      rstSync_q <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstSync_q <= rstMeta_q;
    end
  end

  // =====================================================================
  // bus slave state
  // =====================================================================
  typedef struct packed {
    logic        ack;
    logic        err;
    logic [31:0] rdata;
  } bus_s;

  bus_s bus_q;
  bus_s bus_d;

  logic              req;
  logic              regHit;
  logic [2:0]        regIdx;
  logic [15:0]       readWord;
  logic [15:0]       regWord [NUM_REGS];
  logic [NUM_REGS*FIELDS*FIELD_W-1:0] levelsFlat;
  logic [NUM_REGS*FIELDS-1:0]         fieldWr;

  assign req = wb_cyc_i && wb_stb_i && !bus_q.ack && !bus_q.err;

  always_comb begin
    regHit = 1'b1;
    regIdx = 3'd0;
    unique case (wb_adr_i)
      OFS_GRP5:  regIdx = 3'd0;
      OFS_GRP6:  regIdx = 3'd1;
      OFS_GRP7:  regIdx = 3'd2;
      OFS_GRP8:  regIdx = 3'd3;
      OFS_GRP9:  regIdx = 3'd4;
      OFS_GRP10: regIdx = 3'd5;
      default:   regHit = 1'b0;
    endcase
  end

  // =====================================================================
  // priority fields
  // =====================================================================
  genvar r;
  genvar f;
  generate
    for (r = 0; r < NUM_REGS; r++) begin : g_reg
      for (f = 0; f < FIELDS; f++) begin : g_fld
        // low byte lane holds fields 0-1, upper lane fields 2-3
        assign fieldWr[r*FIELDS+f] = req && wb_we_i && regHit && (regIdx == 3'(r))
                                     && wb_sel_i[f/2];
        prio_field u_field (
          .clk       (clk),
          .rstN      (rstSync_q),
          .wrEn      (fieldWr[r*FIELDS+f]),
          .wrData    (wb_dat_i[f*4 +: FIELD_W]),   // see RL12
          .level     (levelsFlat[(r*FIELDS+f)*FIELD_W +: FIELD_W]),
          .srcEnable (sourceEnable[r*FIELDS+f])    // see RL3
        );
        // bit 3 of each nibble stays zero
        assign regWord[r][f*4 +: 4] = {1'b0, levelsFlat[(r*FIELDS+f)*FIELD_W +: FIELD_W]}; // see RL4

        a_field_holds: assert property (@(posedge clk) disable iff (!rstSync_q) // see RL12
          !fieldWr[r*FIELDS+f] |=> $stable(levelsFlat[(r*FIELDS+f)*FIELD_W +: FIELD_W]))
          else $error("field changed without a write");
      end
    end
  endgenerate

  assign readWord = regWord[regIdx] & IMPL_MASK; // see RL4

  always_comb begin
    bus_d       = bus_q;
    bus_d.ack   = 1'b0;
    bus_d.err   = 1'b0;
    if (req) begin
      bus_d.ack = regHit;
      bus_d.err = !regHit;
      if (!wb_we_i) begin
        bus_d.rdata = regHit ? {16'h0000, readWord} : 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clk or negedge rstSync_q) begin
    if (!rstSync_q) begin
      bus_q <= '{ack: 1'b0, err: 1'b0, rdata: 32'h0000_0000};
    end else begin
      bus_q <= bus_d;
    end
  end

  assign wb_ack_o = bus_q.ack;
  assign wb_err_o = bus_q.err;
  assign wb_dat_o = bus_q.rdata;

  // =====================================================================
  // field outputs
  // =====================================================================
  // field index = reg*4 + (0 for bits 2-0 ... 3 for bits 14-12)
  assign ext_irq1_priority        = levelsFlat[0*3 +: 3];  // see RL6
  assign converter2_done_priority = levelsFlat[1*3 +: 3];  // see RL6
  assign capture7_priority        = levelsFlat[2*3 +: 3];  // see RL6
  assign capture8_priority        = levelsFlat[3*3 +: 3];  // see RL6
  assign dma_ch2_done_priority    = levelsFlat[4*3 +: 3];  // see RL7
  assign compare3_priority        = levelsFlat[5*3 +: 3];  // see RL7
  assign compare4_priority        = levelsFlat[6*3 +: 3];  // see RL7
  assign timer4_priority          = levelsFlat[7*3 +: 3];  // see RL7
  assign timer5_priority          = levelsFlat[8*3 +: 3];  // see RL8
  assign ext_irq2_priority        = levelsFlat[9*3 +: 3];  // see RL8
  assign serial2_rx_priority      = levelsFlat[10*3 +: 3]; // see RL8
  assign serial2_tx_priority      = levelsFlat[11*3 +: 3]; // see RL8
  assign spi2_error_priority      = levelsFlat[12*3 +: 3]; // see RL9
  assign spi2_event_priority      = levelsFlat[13*3 +: 3]; // see RL9
  assign can1_rx_ready_priority   = levelsFlat[14*3 +: 3]; // see RL9
  assign can1_event_priority      = levelsFlat[15*3 +: 3]; // see RL9
  assign dma_ch3_done_priority    = levelsFlat[16*3 +: 3]; // see RL10
  assign capture3_priority        = levelsFlat[17*3 +: 3]; // see RL10
  assign capture4_priority        = levelsFlat[18*3 +: 3]; // see RL10
  assign capture5_priority        = levelsFlat[19*3 +: 3]; // see RL10
  assign capture6_priority        = levelsFlat[20*3 +: 3]; // see RL11
  assign compare5_priority        = levelsFlat[21*3 +: 3]; // see RL11
  assign compare6_priority        = levelsFlat[22*3 +: 3]; // see RL11
  assign compare7_priority        = levelsFlat[23*3 +: 3]; // see RL11

  // =====================================================================
  // checks: bus answers
  // =====================================================================
  a_answer_next: assert property (@(posedge clk) disable iff (!rstSync_q)
    req |=> wb_ack_o != wb_err_o)
    else $error("request not answered");

  a_idle_quiet: assert property (@(posedge clk) disable iff (!rstSync_q)
    !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o && !wb_err_o)
    else $error("answer without request");

  a_answer_excl: assert property (@(posedge clk) disable iff (!rstSync_q)
    !(wb_ack_o && wb_err_o))
    else $error("ack and err together");

  a_ack_one: assert property (@(posedge clk) disable iff (!rstSync_q) // see RL12
    wb_ack_o || wb_err_o |=> !wb_ack_o && !wb_err_o)
    else $error("answer longer than one cycle");

  a_err_unmapped: assert property (@(posedge clk) disable iff (!rstSync_q)
    req && !regHit |=> wb_err_o && !wb_ack_o)
    else $error("unmapped place not refused");

  a_dat_holds: assert property (@(posedge clk) disable iff (!rstSync_q)
    !(req && !wb_we_i) |=> $stable(wb_dat_o))
    else $error("read data moved without a read");

  a_reserved_zero: assert property (@(posedge clk) disable iff (!rstSync_q) // see RL4
    wb_ack_o |-> (wb_dat_o & ~{16'h0000, IMPL_MASK}) == 32'h0000_0000)
    else $error("unbuilt bit reads one");

  // =====================================================================
  // checks: reset, write filtering and enable decode
  // =====================================================================
  a_reset_level: assert property (@(posedge clk) // see RL5
    $rose(rstSync_q) |-> levelsFlat == {NUM_REGS*FIELDS{PRIO_RESET}} && &sourceEnable)
    else $error("reset level wrong");

  a_reset_bus: assert property (@(posedge clk)
    $rose(rstSync_q) |-> !wb_ack_o && !wb_err_o && wb_dat_o == 32'h0000_0000)
    else $error("bus answer left over from reset");

  a_unmapped_keeps: assert property (@(posedge clk) disable iff (!rstSync_q) // see RL12
    req && wb_we_i && !regHit |=> $stable(levelsFlat))
    else $error("unmapped write changed a field");

  a_upper_lanes: assert property (@(posedge clk) disable iff (!rstSync_q) // see RL12
    req && wb_we_i && wb_sel_i[1:0] == 2'b00 |=> $stable(levelsFlat))
    else $error("upper byte lanes wrote a field");

  a_read_keeps: assert property (@(posedge clk) disable iff (!rstSync_q) // see RL12
    req && !wb_we_i |=> $stable(levelsFlat))
    else $error("read changed a field");

  a_top_level: assert property (@(posedge clk) disable iff (!rstSync_q) // see RL1
    timer4_priority == 3'h7 |-> sourceEnable[7])
    else $error("level 7 not enabled");

  a_low_level: assert property (@(posedge clk) disable iff (!rstSync_q) // see RL2
    compare3_priority == 3'h1 |-> sourceEnable[5])
    else $error("level 1 not enabled");

  a_off_level: assert property (@(posedge clk) disable iff (!rstSync_q) // see RL3
    capture6_priority == 3'h0 |-> !sourceEnable[20])
    else $error("level 0 enabled");

  // =====================================================================
  // checks: field layout
  // =====================================================================
  a_grp5_map: assert property (@(posedge clk) disable iff (!rstSync_q) // see RL6
    req && wb_we_i && wb_adr_i == OFS_GRP5 && wb_sel_i[1:0] == 2'b11
    |=> capture8_priority == $past(wb_dat_i[14:12])
    && capture7_priority == $past(wb_dat_i[10:8])
    && converter2_done_priority == $past(wb_dat_i[6:4])
    && ext_irq1_priority == $past(wb_dat_i[2:0]))
    else $error("group 5 layout");

  a_grp6_map: assert property (@(posedge clk) disable iff (!rstSync_q) // see RL7
    req && wb_we_i && wb_adr_i == OFS_GRP6 && wb_sel_i[1:0] == 2'b11
    |=> timer4_priority == $past(wb_dat_i[14:12])
    && compare4_priority == $past(wb_dat_i[10:8])
    && compare3_priority == $past(wb_dat_i[6:4])
    && dma_ch2_done_priority == $past(wb_dat_i[2:0]))
    else $error("group 6 layout");

  a_grp7_map: assert property (@(posedge clk) disable iff (!rstSync_q) // see RL8
    req && wb_we_i && wb_adr_i == OFS_GRP7 && wb_sel_i[1:0] == 2'b11
    |=> serial2_tx_priority == $past(wb_dat_i[14:12])
    && serial2_rx_priority == $past(wb_dat_i[10:8])
    && ext_irq2_priority == $past(wb_dat_i[6:4])
    && timer5_priority == $past(wb_dat_i[2:0]))
    else $error("group 7 layout");

  a_grp8_map: assert property (@(posedge clk) disable iff (!rstSync_q) // see RL9
    req && wb_we_i && wb_adr_i == OFS_GRP8 && wb_sel_i[1:0] == 2'b11
    |=> can1_event_priority == $past(wb_dat_i[14:12])
    && can1_rx_ready_priority == $past(wb_dat_i[10:8])
    && spi2_event_priority == $past(wb_dat_i[6:4])
    && spi2_error_priority == $past(wb_dat_i[2:0]))
    else $error("group 8 layout");

  a_grp9_map: assert property (@(posedge clk) disable iff (!rstSync_q) // see RL10
    req && wb_we_i && wb_adr_i == OFS_GRP9 && wb_sel_i[1:0] == 2'b11
    |=> capture5_priority == $past(wb_dat_i[14:12])
    && capture4_priority == $past(wb_dat_i[10:8])
    && capture3_priority == $past(wb_dat_i[6:4])
    && dma_ch3_done_priority == $past(wb_dat_i[2:0]))
    else $error("group 9 layout");

  a_grp10_map: assert property (@(posedge clk) disable iff (!rstSync_q) // see RL11
    req && wb_we_i && wb_adr_i == OFS_GRP10 && wb_sel_i[1:0] == 2'b11
    |=> compare7_priority == $past(wb_dat_i[14:12])
    && compare6_priority == $past(wb_dat_i[10:8])
    && compare5_priority == $past(wb_dat_i[6:4])
    && capture6_priority == $past(wb_dat_i[2:0]))
    else $error("group 10 layout");

  a_grp5_read: assert property (@(posedge clk) disable iff (!rstSync_q) // see RL6
    req && !wb_we_i && wb_adr_i == OFS_GRP5 |=> wb_dat_o == {16'h0000, 1'b0, capture8_priority,
      1'b0, capture7_priority, 1'b0, converter2_done_priority, 1'b0, ext_irq1_priority})
    else $error("group 5 read layout");

  a_grp6_read: assert property (@(posedge clk) disable iff (!rstSync_q) // see RL7
    req && !wb_we_i && wb_adr_i == OFS_GRP6 |=> wb_dat_o == {16'h0000, 1'b0, timer4_priority,
      1'b0, compare4_priority, 1'b0, compare3_priority, 1'b0, dma_ch2_done_priority})
    else $error("group 6 read layout");

  a_grp7_read: assert property (@(posedge clk) disable iff (!rstSync_q) // see RL8
    req && !wb_we_i && wb_adr_i == OFS_GRP7 |=> wb_dat_o == {16'h0000, 1'b0, serial2_tx_priority,
      1'b0, serial2_rx_priority, 1'b0, ext_irq2_priority, 1'b0, timer5_priority})
    else $error("group 7 read layout");

  a_grp8_read: assert property (@(posedge clk) disable iff (!rstSync_q) // see RL9
    req && !wb_we_i && wb_adr_i == OFS_GRP8 |=> wb_dat_o == {16'h0000, 1'b0, can1_event_priority,
      1'b0, can1_rx_ready_priority, 1'b0, spi2_event_priority, 1'b0, spi2_error_priority})
    else $error("group 8 read layout");

  a_grp9_read: assert property (@(posedge clk) disable iff (!rstSync_q) // see RL10
    req && !wb_we_i && wb_adr_i == OFS_GRP9 |=> wb_dat_o == {16'h0000, 1'b0, capture5_priority,
      1'b0, capture4_priority, 1'b0, capture3_priority, 1'b0, dma_ch3_done_priority})
    else $error("group 9 read layout");

  a_grp10_read: assert property (@(posedge clk) disable iff (!rstSync_q) // see RL11
    req && !wb_we_i && wb_adr_i == OFS_GRP10 |=> wb_dat_o == {16'h0000, 1'b0, compare7_priority,
      1'b0, compare6_priority, 1'b0, compare5_priority, 1'b0, capture6_priority})
    else $error("group 10 read layout");

  c_write: cover property (@(posedge clk) req && wb_we_i && regHit);
  c_read: cover property (@(posedge clk) req && !wb_we_i && regHit);
  c_unmapped: cover property (@(posedge clk) wb_err_o);
  c_disable: cover property (@(posedge clk) sourceEnable == 24'h00_0000);
  c_lane_split: cover property (@(posedge clk) req && wb_we_i && regHit && wb_sel_i[1:0] == 2'b01);

endmodule

// [irq_priority_regs_bench.sv]
// testbench: priority register bank driven over classic wishbone
`timescale 1ns/1ps
module irq_priority_regs_bench;
  import irq_prio_pkg::*;
  `define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin errors++; $display("MISMATCH t=%0t got %h exp %h", $time, (a), (b)); end end

  // =====================================================================
  // signals
  // =====================================================================
  logic        clk;
  logic        rst_n;
  logic        wbCyc;
  logic        wbStb;
  logic        wbWe;
  logic [4:0]  wbAdr;
  logic [31:0] wbDatI;
  logic [3:0]  wbSel;
  logic [31:0] wbDatO;
  logic        wbAck;
  logic        wbErr;
  logic [2:0]  prio [24];
  logic [23:0] sourceEnable;
  logic [33:0] notes [$];
  logic [33:0] note;
  logic [15:0] expReg [6];
  logic [4:0]  offs [6] = '{OFS_GRP5, OFS_GRP6, OFS_GRP7, OFS_GRP8, OFS_GRP9, OFS_GRP10};
  int          errors;
  int          n_compared;
  int          seed;

  irq_priority_regs irq_priority_regs_i (
    .clk(clk), .rst_n(rst_n), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr),
    .wb_dat_i(wbDatI), .wb_sel_i(wbSel), .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .wb_err_o(wbErr),
    .capture8_priority(prio[3]), .capture7_priority(prio[2]), .converter2_done_priority(prio[1]),
    .ext_irq1_priority(prio[0]), .timer4_priority(prio[7]), .compare4_priority(prio[6]),
    .compare3_priority(prio[5]), .dma_ch2_done_priority(prio[4]), .serial2_tx_priority(prio[11]),
    .serial2_rx_priority(prio[10]), .ext_irq2_priority(prio[9]), .timer5_priority(prio[8]),
    .can1_event_priority(prio[15]), .can1_rx_ready_priority(prio[14]), .spi2_event_priority(prio[13]),
    .spi2_error_priority(prio[12]), .capture5_priority(prio[19]), .capture4_priority(prio[18]),
    .capture3_priority(prio[17]), .dma_ch3_done_priority(prio[16]), .compare7_priority(prio[23]),
    .compare6_priority(prio[22]), .compare5_priority(prio[21]), .capture6_priority(prio[20]),
    .sourceEnable(sourceEnable)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // =====================================================================
  // tasks
  // =====================================================================
  task automatic conclude();
    $display("errors=%0d compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // one classic cycle; note carries {is read, expect err, expected data}
  task automatic xfer(input logic we, input logic [4:0] adr, input logic [15:0] d, input logic [3:0] sel,
                      input logic isErr, input logic [15:0] expRd);
    int n;
    n = 0;
    notes.push_back({~we, isErr, 16'h0000, expRd});
    @(posedge clk);
    wbCyc  <= 1'b1;
    wbStb  <= 1'b1;
    wbWe   <= we;
    wbAdr  <= adr;
    wbSel  <= sel;
    wbDatI <= {16'($random(seed)), d};
    @(posedge clk);
    while (wbAck !== 1'b1 && wbErr !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    if (n >= 20) begin
      errors++;
      $display("MISMATCH t=%0t no answer", $time);
    end
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    @(posedge clk);
    #1;
  endtask

  task automatic readAll();
    for (int r = 0; r < 6; r++)
      xfer(1'b0, offs[r], 16'h0000, 4'hf, 1'b0, expReg[r]);
  endtask

  task automatic checkFields();
    for (int i = 0; i < 24; i++) begin
      `CHK(prio[i], expReg[i/4][(i%4)*4 +: 3])
      `CHK(sourceEnable[i], |expReg[i/4][(i%4)*4 +: 3])
    end
  endtask

  // =====================================================================
  // monitor: answers taken against the oldest note
  // =====================================================================
  always @(posedge clk) begin
    if (wbAck === 1'b1 || wbErr === 1'b1) begin
      if (notes.size() == 0) begin
        errors++;
        $display("MISMATCH t=%0t unexpected answer", $time);
      end else begin
        note = notes.pop_front();
        `CHK(wbErr, note[32])
        if (note[33])
          `CHK(wbDatO, note[31:0])
      end
    end
  end

  initial begin
    #200000;
    errors++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    conclude();
  end

  // =====================================================================
  // main sequence
  // =====================================================================
  initial begin
    logic [15:0] d;
    logic [3:0]  sel;
    int          r;
    seed = 12814;
    errors = 0;
    n_compared = 0;
    rst_n = 1'b0;
    {wbCyc, wbStb, wbWe, wbAdr, wbDatI, wbSel} = '0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    for (int k = 0; k < 6; k++)
      expReg[k] = REG_RESET;
    checkFields();
    readAll();
    // every code, with unbuilt bits set in the write data
    for (int c = 0; c < 8; c++) begin
      r = c % 6;
      d = {4{1'b1, 3'(c)}};
      xfer(1'b1, offs[r], d, 4'b0011, 1'b0, 16'h0000);
      expReg[r] = d & IMPL_MASK;
      checkFields();
      xfer(1'b0, offs[r], 16'h0000, 4'hf, 1'b0, expReg[r]);
    end
    // random data and byte lanes
    repeat (30) begin
      r = {$random(seed)} % 6;
      d = 16'($random(seed));
      sel = 4'($random(seed));
      xfer(1'b1, offs[r], d, sel, 1'b0, 16'h0000);
      if (sel[0])
        expReg[r][7:0] = d[7:0] & IMPL_MASK[7:0];
      if (sel[1])
        expReg[r][15:8] = d[15:8] & IMPL_MASK[15:8];
      checkFields();
      xfer(1'b0, offs[r], 16'h0000, 4'hf, 1'b0, expReg[r]);
    end
    // unmapped places refuse and change nothing
    xfer(1'b1, 5'h18, 16'h0000, 4'hf, 1'b1, 16'h0000);
    xfer(1'b0, 5'h1C, 16'h0000, 4'hf, 1'b1, 16'h0000);
    readAll();
    checkFields();
    // reset in mid-run
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    for (int k = 0; k < 6; k++)
      expReg[k] = REG_RESET;
    checkFields();
    @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    readAll();
    conclude();
  end
endmodule
